// >>> swdcfg_cfg.svh
// Constants for the switch diagnostic configuration and fault mask register bank.
`ifndef SWDCFG_CFG_SVH
`define SWDCFG_CFG_SVH

// -----------------------------------------------------------------------------
// Register offsets and reset values
// -----------------------------------------------------------------------------
`define SWD_ADDR_W 7
`define SWD_OFS_LED_FILTER 7'h0d
`define SWD_OFS_WDOG_THR 7'h0e
`define SWD_OFS_PIN_MASK 7'h0f
`define SWD_RST_LED_FILTER 8'h53
`define SWD_RST_WDOG_THR 8'h00
`define SWD_RST_PIN_MASK 8'hbe

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define SWD_B_LED_OC_HIDE 7
`define SWD_B_LATCH_EN 6
`define SWD_B_LONG_BLANK 5
`define SWD_B_FILTER_EN 4
`define SWD_B_STRETCH_HI 3
`define SWD_B_STRETCH_LO 2
`define SWD_B_STATUS_LAMP_SW 1
`define SWD_B_FAULT_LAMP_SW 0
`define SWD_B_WDOG_HI 7
`define SWD_B_WDOG_LO 6
`define SWD_B_PULLUP_HI 5
`define SWD_B_PULLUP_LO 4
`define SWD_B_SHORT_HI 3
`define SWD_B_SHORT_LO 2
`define SWD_B_SYNC_WD_EN 1
`define SWD_B_TURN_ON 0
`define SWD_B_M_COMM 7
`define SWD_B_M_SUPPLY 6
`define SWD_B_M_GOOD 5
`define SWD_B_M_SHORT 4
`define SWD_B_M_OWON 3
`define SWD_B_M_OWOFF 2
`define SWD_B_M_OC 1
`define SWD_B_M_OVL 0

// -----------------------------------------------------------------------------
// Times in their own units and codes
// -----------------------------------------------------------------------------
`define SWD_CLK_HZ 10000000
`define SWD_MS_US 1000
`define SWD_FILT_US 50
`define SWD_BLANK_SHORT_MS 4
`define SWD_BLANK_LONG_MS 8
`define SWD_STRETCH_UNIT_MS 1000
`define SWD_WD_200_MS 200
`define SWD_WD_600_MS 600
`define SWD_WD_1200_MS 1200
`define SWD_CODE_OFF 2'b00
`define SWD_CODE_1 2'b01
`define SWD_CODE_2 2'b10
`define SWD_CODE_3 2'b11
`define SWD_STRAP_STRETCH 2'b10
`define SWD_STRAP_WDOG 2'b11

`endif

// >>> swd_pkg.sv
// Types shared by the switch diagnostic configuration bank.
package swd_pkg;
  // Serial access state, one-hot.
  typedef enum logic [2:0] {
    SWD_IDLE = 3'b001,
    SWD_SHIFT = 3'b010,
    SWD_DONE = 3'b100
  } swd_state_t;
  // Timer code for a watchdog: 0 disables the serial watchdog.
  typedef logic [1:0] swd_code_t;
endpackage : swd_pkg

// >>> swd_lamp_if.sv
// Interface carrying per-channel fault lamp settings to the lamp timer.
`timescale 1ns/1ps
interface swd_lamp_if;
  logic long_blank; // Long blanking selected.
  logic [1:0] stretch; // Minimum on-time code.
  logic [7:0] fault_raw; // Raw diagnostic faults per channel.
  logic tick_ms; // One-millisecond enable.
  logic [7:0] lamp; // Timed lamp drive.
  modport core (output long_blank, output stretch, output fault_raw, output tick_ms,
    input lamp);
  modport timer (input long_blank, input stretch, input fault_raw, input tick_ms,
    output lamp);
endinterface : swd_lamp_if

// >>> swd_lamp_timer.sv
// Per-channel fault lamp blanking and minimum on-time timer.
`timescale 1ns/1ps
`include "swdcfg_cfg.svh"
module swd_lamp_timer #(
  parameter int CH = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Lamp controls.
  swd_lamp_if.timer lk
);
  // Blanking and stretch counters per channel, in milliseconds.
  logic [3:0] blank_cnt [CH];
  logic [11:0] hold_cnt [CH];
  logic [CH-1:0] lamp_q;
  wire [3:0] blank_lim = lk.long_blank ? 4'(`SWD_BLANK_LONG_MS) : 4'(`SWD_BLANK_SHORT_MS);
  wire [11:0] hold_lim = 12'(`SWD_STRETCH_UNIT_MS) * 12'(lk.stretch);
  assign lk.lamp = lamp_q;

  // -----------------------------------------------------------------------------
  // Channel timers
  // -----------------------------------------------------------------------------
  // Blanking always applies here; the lamp ignores the latch setting.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < CH; i++) begin
      if (!reset_n) begin
        blank_cnt[i] <= 4'h0;
        hold_cnt[i] <= 12'h000;
        lamp_q[i] <= 1'b0;
      end else if (!lk.fault_raw[i]) begin
        // Fault gone: keep lamp only while the stretch time runs.
        blank_cnt[i] <= 4'h0;
        if (hold_cnt[i] == 12'h000) begin
          lamp_q[i] <= 1'b0;
        end else if (lk.tick_ms) begin
          hold_cnt[i] <= hold_cnt[i] - 12'h001;
        end
      end else if (lamp_q[i]) begin
        // Lit: no reload; minimum on-time counts down from turn-on only.
        if (lk.tick_ms && hold_cnt[i] != 12'h000) begin
          hold_cnt[i] <= hold_cnt[i] - 12'h001;
        end
      end else if (lk.tick_ms) begin
        if (blank_cnt[i] + 4'h1 >= blank_lim) begin
          lamp_q[i] <= 1'b1;
          hold_cnt[i] <= hold_lim;
        end else begin
          blank_cnt[i] <= blank_cnt[i] + 4'h1;
        end
      end
    end
  end
endmodule : swd_lamp_timer

// >>> swd_config_bank.sv
// Configuration and fault-pin mask register bank with lamp, watchdog and fault routing.
`timescale 1ns/1ps
`include "swdcfg_cfg.svh"
module swd_config_bank #(
  parameter int CH = 8,
  parameter int WD_1200_CYC = `SWD_WD_1200_MS * (`SWD_CLK_HZ / 1000),
  parameter int WD_600_CYC = `SWD_WD_600_MS * (`SWD_CLK_HZ / 1000),
  parameter int WD_200_CYC = `SWD_WD_200_MS * (`SWD_CLK_HZ / 1000),
  parameter int MS_CYC = `SWD_CLK_HZ / 1000
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial register port pins, asynchronous to sys_clk.
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Strap and sync pins.
  input wire logic chain_strap,
  input wire logic addr0_strap,
  input wire logic addr1_strap,
  input wire logic checksum_enable_pin,
  input wire logic sync_pin,
  // Raw diagnostics per channel, same clock domain.
  input wire logic [CH-1:0] overload_raw,
  input wire logic [CH-1:0] overcurrent_raw,
  input wire logic [CH-1:0] open_wire_off_raw,
  input wire logic [CH-1:0] open_wire_on_raw,
  input wire logic [CH-1:0] short_supply_raw,
  input wire logic [CH-1:0] short_supply_en,
  input wire logic supply_not_good_flag,
  input wire logic supply_warning_flag,
  input wire logic supply_other_err,
  // Lamp set registers held elsewhere.
  input wire logic [CH-1:0] status_led_drive_reg,
  input wire logic [CH-1:0] fault_led_drive_reg,
  input wire logic [CH-1:0] status_auto,
  // Lamp outputs.
  output logic [CH-1:0] fault_lamp,
  output logic [CH-1:0] status_lamp,
  // Fault class outputs and flags.
  output logic fault_pin_n,
  output logic comm_error_flag,
  output logic supply_error_flag,
  output logic voltage_error_flag,
  output logic global_interrupt_flag,
  output logic fault_latch_enable,
  output logic fault_filter_enable,
  output logic long_blanking_select,
  output logic [1:0] pullup_current,
  output logic [1:0] short_supply_level,
  output logic turn_on_level_select,
  output logic [CH-1:0] short_supply_det_en,
  output logic open_wire_det_en
);
  // -----------------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------------
  logic [7:0] pin_s1; // First stage, read only by the second.
  logic [7:0] pin_s2;
  logic sck_d; // Previous sampled serial clock for edge finding.
  logic sync_d;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      // Both stages reset to the idle select level, so no false frame start follows reset.
      pin_s1 <= 8'h01;
      pin_s2 <= 8'h01;
      sck_d <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      pin_s1 <= {checksum_enable_pin, chain_strap, sync_pin, addr1_strap, addr0_strap,
          spi_mosi, spi_clk, spi_cs_n};
      pin_s2 <= pin_s1;
      sck_d <= pin_s2[1];
      sync_d <= pin_s2[5];
    end
  end
  wire cs_n = pin_s2[0];
  wire sck_rise = pin_s2[1] & ~sck_d;
  wire sck_fall = ~pin_s2[1] & sck_d;
  wire mosi = pin_s2[2];
  wire sync_edge = pin_s2[5] ^ sync_d;
  // Strap levels are sampled through the same synchronisers.
  wire daisy = pin_s2[6];
  wire cksum_en = pin_s2[7];

  // -----------------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------------
  logic [7:0] led_and_filter_config;
  logic [7:0] watchdog_and_threshold_config;
  logic [7:0] fault_pin_mask;

  // -----------------------------------------------------------------------------
  // Serial frame: 16 bits, read flag, 7-bit address, 8 data bits, MSB first
  // -----------------------------------------------------------------------------
  swd_pkg::swd_state_t state;
  swd_pkg::swd_state_t next_state;
  logic [4:0] bit_cnt;
  logic [15:0] shreg;
  logic [7:0] rd_shift;
  logic spi_activity; // One-cycle pulse at each completed frame.
  wire frame_done = sck_rise && bit_cnt == 5'd15;
  wire [6:0] f_addr = shreg[13:7];
  wire f_read = shreg[14];
  wire [7:0] f_data = {shreg[6:0], mosi};
  wire hit_led = f_addr == `SWD_OFS_LED_FILTER;
  wire hit_wdt = f_addr == `SWD_OFS_WDOG_THR;
  wire hit_msk = f_addr == `SWD_OFS_PIN_MASK;
  wire [6:0] rd_addr = {shreg[5:0], mosi}; // Address is complete at the eighth rise.
  wire [7:0] rd_val = (rd_addr == `SWD_OFS_LED_FILTER) ? led_and_filter_config :
                      (rd_addr == `SWD_OFS_WDOG_THR) ? watchdog_and_threshold_config :
                      (rd_addr == `SWD_OFS_PIN_MASK) ? fault_pin_mask : 8'h00;
  wire load_rd = sck_rise && bit_cnt == 5'd7;

  // Next state of the frame sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      swd_pkg::SWD_IDLE: if (!cs_n) next_state = swd_pkg::SWD_SHIFT;
      swd_pkg::SWD_SHIFT: begin
        if (cs_n) next_state = swd_pkg::SWD_IDLE;
        else if (frame_done) next_state = swd_pkg::SWD_DONE;
      end
      swd_pkg::SWD_DONE: if (cs_n) next_state = swd_pkg::SWD_IDLE;
      default: next_state = swd_pkg::SWD_IDLE;
    endcase
  end

  // Shifter; an aborted frame leaves the registers untouched.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= swd_pkg::SWD_IDLE;
      bit_cnt <= 5'd0;
      shreg <= 16'h0000;
      rd_shift <= 8'h00;
      spi_miso <= 1'b0;
      spi_activity <= 1'b0;
    end else begin
      state <= next_state;
      spi_activity <= frame_done && state == swd_pkg::SWD_SHIFT;
      if (state != swd_pkg::SWD_SHIFT) begin
        bit_cnt <= 5'd0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 5'd1;
        shreg <= {shreg[14:0], mosi};
      end
      if (load_rd) begin
        rd_shift <= {rd_val[6:0], 1'b0};
        spi_miso <= rd_val[7];
      end else if (sck_fall && bit_cnt > 5'd8) begin
        spi_miso <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end
  // The read value uses address bits complete at bit 8.
  // Write decode happens at the last rising edge.
  wire wr_en = frame_done && state == swd_pkg::SWD_SHIFT && !f_read;

  // Register writes.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      led_and_filter_config <= `SWD_RST_LED_FILTER;
      watchdog_and_threshold_config <= `SWD_RST_WDOG_THR;
      fault_pin_mask <= `SWD_RST_PIN_MASK;
    end else if (wr_en) begin
      if (hit_led) led_and_filter_config <= f_data;
      if (hit_wdt) watchdog_and_threshold_config <= f_data;
      if (hit_msk) fault_pin_mask <= f_data;
    end
  end

  // -----------------------------------------------------------------------------
  // Field decode with strap overrides
  // -----------------------------------------------------------------------------
  wire led_overcurrent_hide = led_and_filter_config[`SWD_B_LED_OC_HIDE] | daisy;
  wire fault_led_sw_control = led_and_filter_config[`SWD_B_FAULT_LAMP_SW] & ~daisy;
  wire status_led_sw_control = led_and_filter_config[`SWD_B_STATUS_LAMP_SW] & ~daisy;
  wire [1:0] stretch = daisy ? `SWD_STRAP_STRETCH :
      {led_and_filter_config[`SWD_B_STRETCH_HI], led_and_filter_config[`SWD_B_STRETCH_LO]};
  wire [1:0] wdog_code = daisy ? `SWD_STRAP_WDOG :
      {watchdog_and_threshold_config[`SWD_B_WDOG_HI],
       watchdog_and_threshold_config[`SWD_B_WDOG_LO]};
  wire spi_wd_on = daisy ? pin_s2[3] : (wdog_code != `SWD_CODE_OFF);
  wire sync_wd_on = daisy ? pin_s2[4] :
      watchdog_and_threshold_config[`SWD_B_SYNC_WD_EN];

  // Timeout in cycles for a code; code 00 means 600ms for the sync timer.
  function automatic logic [31:0] wd_limit(input logic [1:0] code);
    unique case (code)
      `SWD_CODE_1: wd_limit = 32'(WD_200_CYC);
      `SWD_CODE_3: wd_limit = 32'(WD_1200_CYC);
      default: wd_limit = 32'(WD_600_CYC);
    endcase
  endfunction : wd_limit

  // -----------------------------------------------------------------------------
  // Millisecond divider and watchdogs
  // -----------------------------------------------------------------------------
  logic [15:0] ms_cnt;
  logic tick_ms;
  logic [31:0] spi_wd_cnt;
  logic [31:0] sync_wd_cnt;
  logic comm_event;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ms_cnt <= 16'h0000;
      tick_ms <= 1'b0;
      spi_wd_cnt <= 32'h0000_0000;
      sync_wd_cnt <= 32'h0000_0000;
      comm_event <= 1'b0;
    end else begin
      tick_ms <= ms_cnt == 16'(MS_CYC - 1);
      ms_cnt <= (ms_cnt == 16'(MS_CYC - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
      // Counters restart on activity and hold at the limit.
      spi_wd_cnt <= (spi_activity || !spi_wd_on) ? 32'h0000_0000 :
          (spi_wd_cnt == wd_limit(wdog_code)) ? spi_wd_cnt : spi_wd_cnt + 32'h0000_0001;
      sync_wd_cnt <= (sync_edge || !sync_wd_on) ? 32'h0000_0000 :
          (sync_wd_cnt == wd_limit(wdog_code)) ? sync_wd_cnt : sync_wd_cnt + 32'h0000_0001;
      comm_event <= (spi_wd_on && spi_wd_cnt == wd_limit(wdog_code)) ||
          (sync_wd_on && sync_wd_cnt == wd_limit(wdog_code));
    end
  end

  // -----------------------------------------------------------------------------
  // Fault lamp timer
  // -----------------------------------------------------------------------------
  swd_lamp_if lk ();
  // Internal lamp sources; strap leaves overload only.
  assign lk.fault_raw = daisy ? overload_raw :
      (overload_raw | (led_overcurrent_hide ? '0 : overcurrent_raw) | open_wire_off_raw |
       open_wire_on_raw | (short_supply_raw & short_supply_en));
  assign lk.long_blank = led_and_filter_config[`SWD_B_LONG_BLANK];
  assign lk.stretch = stretch;
  assign lk.tick_ms = tick_ms;
  swd_lamp_timer #(.CH(CH)) u_lamp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .lk(lk.timer)
  );

  // -----------------------------------------------------------------------------
  // Fault pin routing
  // -----------------------------------------------------------------------------
  wire ov_cls = |overload_raw & ~fault_pin_mask[`SWD_B_M_OVL];
  wire oc_cls = |overcurrent_raw & ~fault_pin_mask[`SWD_B_M_OC] & ~daisy;
  wire sh_cls = |(short_supply_raw & short_supply_en) & ~fault_pin_mask[`SWD_B_M_SHORT]
      & ~daisy;
  wire on_cls = |open_wire_on_raw & ~fault_pin_mask[`SWD_B_M_OWON] & ~daisy;
  wire off_cls = |open_wire_off_raw & ~fault_pin_mask[`SWD_B_M_OWOFF] & ~daisy;
  wire good_part = (supply_not_good_flag | supply_warning_flag) &
      ~fault_pin_mask[`SWD_B_M_GOOD];
  wire next_supply_err = supply_other_err | good_part;
  wire sup_cls = next_supply_err & ~fault_pin_mask[`SWD_B_M_SUPPLY] & ~daisy;
  wire com_cls = comm_event & ~fault_pin_mask[`SWD_B_M_COMM] & ~daisy;

  // Registered outputs.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fault_pin_n <= 1'b1;
      comm_error_flag <= 1'b0;
      supply_error_flag <= 1'b0;
      voltage_error_flag <= 1'b0;
      global_interrupt_flag <= 1'b0;
      fault_lamp <= '0;
      status_lamp <= '0;
      fault_latch_enable <= 1'b1;
      fault_filter_enable <= 1'b1;
      long_blanking_select <= 1'b0;
      pullup_current <= 2'b00;
      short_supply_level <= 2'b00;
      turn_on_level_select <= 1'b0;
      short_supply_det_en <= '0;
      open_wire_det_en <= 1'b0;
    end else begin
      fault_pin_n <= ~(ov_cls | oc_cls | sh_cls | on_cls | off_cls | sup_cls | com_cls);
      // Flag shows only with checksum enabled under the strap.
      comm_error_flag <= comm_event & (~daisy | cksum_en);
      supply_error_flag <= next_supply_err;
      voltage_error_flag <= next_supply_err;
      global_interrupt_flag <= comm_event | next_supply_err | (|overload_raw) |
          (|overcurrent_raw);
      fault_lamp <= fault_led_sw_control ? fault_led_drive_reg : lk.lamp;
      status_lamp <= status_led_sw_control ? status_led_drive_reg : status_auto;
      fault_latch_enable <= led_and_filter_config[`SWD_B_LATCH_EN];
      fault_filter_enable <= led_and_filter_config[`SWD_B_FILTER_EN];
      long_blanking_select <= led_and_filter_config[`SWD_B_LONG_BLANK];
      pullup_current <= {watchdog_and_threshold_config[`SWD_B_PULLUP_HI],
          watchdog_and_threshold_config[`SWD_B_PULLUP_LO]};
      short_supply_level <= {watchdog_and_threshold_config[`SWD_B_SHORT_HI],
          watchdog_and_threshold_config[`SWD_B_SHORT_LO]};
      turn_on_level_select <= watchdog_and_threshold_config[`SWD_B_TURN_ON] | daisy;
      short_supply_det_en <= daisy ? '0 : short_supply_en;
      open_wire_det_en <= ~daisy;
    end
  end
endmodule : swd_config_bank

// >>> swd_config_bank_properties.sv
// Concurrent checks on the ports of the configuration and fault mask bank.
`timescale 1ns/1ps
module swd_config_bank_properties (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Watched inputs.
  input wire logic spi_cs_n,
  input wire logic chain_strap,
  input wire logic supply_other_err,
  input wire logic [7:0] overload_raw,
  input wire logic [7:0] status_auto,
  // Watched outputs.
  input wire logic [7:0] status_lamp,
  input wire logic fault_pin_n,
  input wire logic comm_error_flag,
  input wire logic supply_error_flag,
  input wire logic global_interrupt_flag,
  input wire logic fault_latch_enable,
  input wire logic fault_filter_enable,
  input wire logic [1:0] pullup_current,
  input wire logic [1:0] short_supply_level,
  input wire logic turn_on_level_select,
  input wire logic [7:0] short_supply_det_en,
  input wire logic open_wire_det_en
);
  // ---------------------------------------------------------------------------
  // Helper history
  // ---------------------------------------------------------------------------
  // Edges since reset release, so that no check looks back into a reset.
  logic [3:0] up;
  // Strap seen high on the last three edges after release.
  logic [2:0] sh;
  // Both shift registers clear in reset; afterwards up fills with ones and sh with the strap level.
  always_ff @(posedge sys_clk) begin
    up <= reset_n ? {up[2:0], 1'h1} : 4'h0;
    sh <= reset_n ? {sh[1:0], chain_strap} : 3'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  chk_reset_cfg_on:
    assert property ($rose(reset_n) |-> fault_latch_enable && fault_filter_enable)
    else $error("latch or filter enable not set out of reset");
  chk_strap_no_detect:
    assert property (&sh |-> short_supply_det_en == 8'h00 && !open_wire_det_en)
    else $error("detection left on under strap");
  chk_strap_turn_on:
    assert property (&sh |-> turn_on_level_select)
    else $error("good threshold not forced under strap");
  chk_strap_status_auto:
    assert property (&sh && status_auto == $past(status_auto) &&
      status_auto == $past(status_auto, 2) |-> status_lamp == status_auto)
    else $error("status lamps not autonomous under strap");
  chk_strap_pin_quiet:
    assert property (&sh && overload_raw == 8'h00 && $past(overload_raw) == 8'h00
      |-> fault_pin_n)
    else $error("fault pin driven under strap without overload");
  chk_supply_flag_set:
    assert property (up[2] && !chain_strap && supply_other_err && $past(supply_other_err)
      && $past(supply_other_err, 2) |-> supply_error_flag)
    else $error("supply error flag missing");
  chk_global_flag_follow:
    assert property ((comm_error_flag || supply_error_flag) |-> ##[0:2] global_interrupt_flag)
    else $error("global flag missing");
  chk_cfg_quiet_idle:
    assert property ((up[3] && spi_cs_n) [*8] |->
      $stable({pullup_current, short_supply_level, turn_on_level_select}))
    else $error("config outputs moved without a frame");
  // Main scenarios reached.
  cover property (&sh);
  cover property (comm_error_flag);
  cover property ($changed(pullup_current));
endmodule : swd_config_bank_properties

bind swd_config_bank swd_config_bank_properties chk_u (.sys_clk, .reset_n, .spi_cs_n,
  .chain_strap, .supply_other_err, .overload_raw, .status_auto, .status_lamp, .fault_pin_n,
  .comm_error_flag, .supply_error_flag, .global_interrupt_flag, .fault_latch_enable,
  .fault_filter_enable, .pullup_current, .short_supply_level, .turn_on_level_select,
  .short_supply_det_en, .open_wire_det_en);

// >>> swd_host.sv
// Behavioural serial host that reads and writes the configuration bank.
`timescale 1ns/1ps
module swd_host (
  // Serial pins.
  output logic spi_cs_n,
  output logic spi_clk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // The link clock stands low and the select high outside frames.
  initial begin
    spi_cs_n = 1'h1;
    spi_clk = 1'h0;
    spi_mosi = 1'h0;
  end
  // One 16-bit frame at 800 ns per bit; the answer is taken on the last 8 rises.
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
    output logic [7:0] q);
    logic [15:0] w;
    w = {rd, adr, wd};
    q = 8'h00;
    #37;
    spi_cs_n = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #400;
      spi_clk = 1'h1;
      q = (i < 8) ? {q[6:0], spi_miso} : q;
      #400;
      spi_clk = 1'h0;
    end
    // A released data line shows the inverse of its last bit, never a held value.
    spi_mosi = ~spi_mosi;
    #400;
    spi_cs_n = 1'h1;
    #400;
  endtask : xfer
endmodule : swd_host

// >>> tb_top.sv
// Self-checking bench for the configuration and fault mask bank.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("FAIL %0t %h vs %h", $time, a, b); end end
module tb_top;
  // ---------------------------------------------------------------------------
  // Pins and counters
  // ---------------------------------------------------------------------------
  int n_errors = 0;
  int compares = 0;
  logic sys_clk = 1'h0, reset_n = 1'h0, chain_strap = 1'h0;
  logic addr0_strap = 1'h0, addr1_strap = 1'h0, checksum_enable_pin = 1'h0, sync_pin = 1'h0;
  logic supply_not_good_flag = 1'h0, supply_warning_flag = 1'h0, supply_other_err = 1'h0;
  logic [7:0] overload_raw = 8'h00, overcurrent_raw = 8'h00, open_wire_off_raw = 8'h00;
  logic [7:0] open_wire_on_raw = 8'h00, short_supply_raw = 8'h00, short_supply_en = 8'h00;
  logic [7:0] status_led_drive_reg = 8'h00, fault_led_drive_reg = 8'h00, status_auto = 8'h00;
  logic spi_cs_n, spi_clk, spi_mosi, spi_miso, fault_pin_n, comm_error_flag, supply_error_flag;
  logic voltage_error_flag, global_interrupt_flag, fault_latch_enable, fault_filter_enable;
  logic long_blanking_select, turn_on_level_select, open_wire_det_en;
  logic [1:0] pullup_current, short_supply_level;
  logic [7:0] fault_lamp, status_lamp, short_supply_det_en;
  // Short timer counts keep the watchdog and lamp scenarios within the run budget.
  swd_config_bank #(.WD_1200_CYC(1200), .WD_600_CYC(600), .WD_200_CYC(200), .MS_CYC(10))
    dut_u (.*);
  swd_host host_u (.spi_cs_n, .spi_clk, .spi_mosi, .spi_miso);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // A hang counts as a mismatch.
  initial begin
    #5000000;
    n_errors++;
    conclude();
  end
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Outputs are judged on the falling edge, well clear of updates.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(1'h0, a, d, q);
    step(4);
  endtask : wr
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    host_u.xfer(1'h1, a, 8'h00, q);
    `CHK(q, e)
  endtask : rd_chk
  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values, then an unmapped place that must stay empty.
  task automatic t_regs();
    rd_chk(7'h0d, 8'h53);
    rd_chk(7'h0e, 8'h00);
    rd_chk(7'h0f, 8'hbe);
    `CHK(fault_latch_enable, 1'h1)
    `CHK(fault_filter_enable, 1'h1)
    wr(7'h10, 8'h55);
    rd_chk(7'h10, 8'h00);
  endtask : t_regs
  // Every pull-up and threshold code reaches its outputs.
  task automatic t_cfg2();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(7'h0e, {2'h0, c, c, 2'h1});
      `CHK(pullup_current, c)
      `CHK(short_supply_level, c)
      `CHK(turn_on_level_select, 1'h1)
      rd_chk(7'h0e, {2'h0, c, c, 2'h1});
    end
  endtask : t_cfg2
  task automatic t_cfg1();
    wr(7'h0d, 8'hb3);
    `CHK(fault_latch_enable, 1'h0)
    `CHK(long_blanking_select, 1'h1)
    wr(7'h0d, 8'h83);
    `CHK(fault_filter_enable, 1'h0)
    `CHK(long_blanking_select, 1'h0)
  endtask : t_cfg1
  // Register control, then internal control with filtering switched off.
  task automatic t_lamps();
    @(posedge sys_clk);
    status_led_drive_reg <= 8'h3c;
    fault_led_drive_reg <= 8'ha5;
    status_auto <= 8'h81;
    step(4);
    `CHK(status_lamp, 8'h3c)
    `CHK(fault_lamp, 8'ha5)
    wr(7'h0d, 8'h80);
    `CHK(status_lamp, 8'h81)
    @(posedge sys_clk);
    overload_raw <= 8'h01;
    step(30);
    `CHK(fault_lamp, 8'h00)
    step(35);
    `CHK(fault_lamp, 8'h01)
    @(posedge sys_clk);
    overload_raw <= 8'h00;
    step(15);
    `CHK(fault_lamp, 8'h00)
    // A one-second stretch keeps a short fault lit well past its end.
    wr(7'h0d, 8'h84);
    @(posedge sys_clk);
    overload_raw <= 8'h01;
    step(65);
    @(posedge sys_clk);
    overload_raw <= 8'h00;
    step(5000);
    `CHK(fault_lamp, 8'h01)
    step(5100);
    `CHK(fault_lamp, 8'h00)
  endtask : t_lamps
  task automatic t_mask();
    @(posedge sys_clk);
    overcurrent_raw <= 8'hff;
    open_wire_on_raw <= 8'hff;
    open_wire_off_raw <= 8'hff;
    short_supply_raw <= 8'hff;
    short_supply_en <= 8'hff;
    step(6);
    `CHK(fault_pin_n, 1'h1)
    @(posedge sys_clk);
    overload_raw <= 8'h01;
    step(6);
    `CHK(fault_pin_n, 1'h0)
    wr(7'h0f, 8'hbf);
    `CHK(fault_pin_n, 1'h1)
    @(posedge sys_clk);
    overload_raw <= 8'h00;
    supply_other_err <= 1'h1;
    step(6);
    `CHK(fault_pin_n, 1'h0)
    wr(7'h0f, 8'hff);
    `CHK(fault_pin_n, 1'h1)
    `CHK(supply_error_flag, 1'h1)
    @(posedge sys_clk);
    supply_other_err <= 1'h0;
    supply_not_good_flag <= 1'h1;
    supply_warning_flag <= 1'h1;
    step(6);
    `CHK(supply_error_flag, 1'h0)
    wr(7'h0f, 8'hdf);
    `CHK(supply_error_flag, 1'h1)
  endtask : t_mask
  // A 200-cycle watchdog fires with no frame, yet stays off the pin.
  task automatic t_wdog();
    @(posedge sys_clk);
    overcurrent_raw <= 8'h00;
    supply_not_good_flag <= 1'h0;
    supply_warning_flag <= 1'h0;
    wr(7'h0e, 8'h40);
    step(150);
    `CHK(comm_error_flag, 1'h0)
    `CHK(global_interrupt_flag, 1'h0)
    step(100);
    `CHK(comm_error_flag, 1'h1)
    `CHK(global_interrupt_flag, 1'h1)
    `CHK(fault_pin_n, 1'h1)
  endtask : t_wdog
  // The strap is static, so it changes only under a fresh reset.
  task automatic t_strap();
    @(posedge sys_clk);
    reset_n <= 1'h0;
    chain_strap <= 1'h1;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'h1;
    step(6);
    `CHK(turn_on_level_select, 1'h1)
    `CHK(short_supply_det_en, 8'h00)
    `CHK(open_wire_det_en, 1'h0)
    `CHK(status_lamp, 8'h81)
    `CHK(fault_pin_n, 1'h1)
  endtask : t_strap
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'h1;
    step(4);
    t_regs();
    t_cfg2();
    t_cfg1();
    t_lamps();
    t_mask();
    t_wdog();
    t_strap();
    conclude();
  end
endmodule : tb_top
